// [rtl/hli_top.sv]
// Host link command interpreter: identifier read/write and I/O channel reads
//
// Overview of operation
// - Multi-point frames carry @ and identifier first, check characters after data.
// - All commands work in both point-to-point and multi-point modes.
// - Identifier is one byte, returned as two hex ASCII characters.
// - Point-to-point frames are handled regardless of the identifier.
// - Identifier lives in non-volatile storage until the next write.
// - Identifier write: header, two hex characters, asterisk; value stored.
// - Read-input: header, channel as two hex characters, asterisk.
// - Channel n bit k is input 8n+k+1; channels 00 to 1F.
// - Channel reply: same header, byte as two hex characters, asterisk.
// - Read-output uses same numbering and reply, from the output image.
// - Multi-point frames answered only when the identifier matches ours.
`default_nettype none

module hli_top #(
    parameter int NUM_CH = 32
) (
    input  wire logic                 clk,
    input  wire logic                 nrst,
    input  wire logic                 multipoint_pin,
    input  wire logic [7:0]           rx_data,
    input  wire logic                 rx_valid,
    output logic      [7:0]           tx_data,
    output logic                      tx_valid,
    input  wire logic                 tx_ready,
    input  wire logic [NUM_CH*8-1:0]  in_image,
    input  wire logic [NUM_CH*8-1:0]  out_image,
    input  wire logic [7:0]           nv_id,
    output logic                      nv_wr,
    output logic      [7:0]           nv_wr_id,
    output logic      [7:0]           dev_id,
    output logic                      multipoint
);
    import hli_pkg::*;

    hli_state_s              r;
    hli_state_s              n;

    logic [`HLI_CNT_W-1:0]   ofs;
    logic [7:0]              hdr0;
    logic [7:0]              hdr1;
    logic                    is_id_rd;
    logic                    is_id_wr;
    logic                    is_rd_in;
    logic                    is_rd_out;
    logic                    has_data;
    logic [`HLI_CNT_W-1:0]   need_len;
    logic [7:0]              id_field;
    logic                    id_field_ok;
    logic [7:0]              data_val;
    logic                    data_ok;
    logic [7:0]              chk_rx;
    logic                    chk_rx_ok;
    logic [7:0]              chk_calc;
    logic [`HLI_CNT_W-1:0]   chk_end;
    logic                    frame_ok;
    logic                    addr_ok;
    logic                    accept;
    logic [4:0]              chan;
    logic [7:0]              img_byte;
    logic [7:0]              img_ofs;
    logic [7:0]              rep_val;
    logic [7:0]              rid_hi;
    logic [7:0]              rid_lo;
    logic [7:0]              rval_hi;
    logic [7:0]              rval_lo;
    logic [7:0]              rchk;
    logic [7:0]              rchk_hi;
    logic [7:0]              rchk_lo;
    logic [`HLI_BUF_LEN-1:0][7:0] rep;
    logic [`HLI_CNT_W-1:0]   rep_len;
    logic [`HLI_CNT_W-1:0]   body_len;

    // Command field sits after the identifier prefix in multi-point mode
    assign ofs  = r.mp ? `HLI_MP_PFX : 4'h0;
    assign hdr0 = r.rxb[ofs];
    assign hdr1 = r.rxb[4'(ofs + 4'h1)];

    // Only these four headers are served; anything else stays silent
    assign is_id_rd  = (hdr0 == `HLI_CHAR_I) && (hdr1 == `HLI_CHAR_R);
    assign is_id_wr  = (hdr0 == `HLI_CHAR_I) && (hdr1 == `HLI_CHAR_W);
    assign is_rd_in  = (hdr0 == `HLI_CHAR_R) && (hdr1 == `HLI_CHAR_I);
    assign is_rd_out = (hdr0 == `HLI_CHAR_R) && (hdr1 == `HLI_CHAR_O);
    assign has_data  = is_id_wr | is_rd_in | is_rd_out;

    // Expected length: header, optional two data chars, asterisk, plus framing
    always_comb begin
        need_len = 4'(`HLI_HDR_LEN + 4'h1);
        if (has_data) begin
            need_len = 4'(need_len + `HLI_DATA_LEN);
        end
        if (r.mp) begin
            need_len = 4'(need_len + `HLI_MP_PFX + `HLI_CHK_LEN);
        end
    end

    // Identifier prefix always sits right after the at sign
    hli_hex_dec u_dec_id (
        .hi_char (r.rxb[1]),
        .lo_char (r.rxb[2]),
        .value   (id_field),
        .ok      (id_field_ok)
    );

    // Lower-case hex is taken on input; replies are always upper case
    hli_hex_dec u_dec_data (
        .hi_char (r.rxb[4'(ofs + 4'h2)]),
        .lo_char (r.rxb[4'(ofs + 4'h3)]),
        .value   (data_val),
        .ok      (data_ok)
    );

    // Received check characters precede the asterisk
    assign chk_end = (r.cnt > 4'h3) ? 4'(r.cnt - 4'h3) : 4'h0;

    hli_hex_dec u_dec_chk (
        .hi_char (r.rxb[chk_end]),
        .lo_char (r.rxb[4'(chk_end + 4'h1)]),
        .value   (chk_rx),
        .ok      (chk_rx_ok)
    );

    // XOR of every character ahead of the check characters
    // Bound by chk_end so check characters and terminator stay out of the sum
    always_comb begin
        chk_calc = 8'h00;
        for (int i = 0; i < `HLI_BUF_LEN; i++) begin
            if (i < int'(chk_end)) begin
                chk_calc = chk_calc ^ r.rxb[i];
            end
        end
    end

    // Exact length, terminator and a known, well-formed header must all hold
    assign frame_ok = !r.ovf && (r.cnt == need_len)
                      && (r.rxb[4'(r.cnt - 4'h1)] == `HLI_CHAR_STAR)
                      && (is_id_rd || (has_data && data_ok));

    // Identifier only matters for multi-point addressing
    assign addr_ok = !r.mp
                     || ((r.rxb[0] == `HLI_CHAR_AT) && id_field_ok && (id_field == r.dev_id)
                         && chk_rx_ok && (chk_rx == chk_calc));

    // Eight points per channel, lowest-numbered point in bit 0
    assign chan     = data_val[4:0];
    assign img_ofs  = {chan, 3'h0};
    assign img_byte = is_rd_in ? in_image[img_ofs +: 8]
                               : out_image[img_ofs +: 8];

    // Out-of-range channels get no answer rather than a made-up byte
    // Narrower builds also stay silent beyond their own image
    assign accept = frame_ok && addr_ok
                    && (!(is_rd_in || is_rd_out) || (data_val <= `HLI_MAX_CH))
                    && (!(is_rd_in || is_rd_out) || (int'(data_val) < NUM_CH));

    assign rep_val = is_id_rd ? r.dev_id : img_byte;

    // Prefix carries the identifier in force while the frame was judged
    hli_hex_enc u_enc_id (
        .value   (r.dev_id),
        .hi_char (rid_hi),
        .lo_char (rid_lo)
    );

    hli_hex_enc u_enc_val (
        .value   (rep_val),
        .hi_char (rval_hi),
        .lo_char (rval_lo)
    );

    // Reply check built from parts to avoid a loop through the reply array
    assign rchk = `HLI_CHAR_AT ^ rid_hi ^ rid_lo ^ hdr0 ^ hdr1
                  ^ (is_id_wr ? 8'h00 : (rval_hi ^ rval_lo));

    hli_hex_enc u_enc_chk (
        .value   (rchk),
        .hi_char (rchk_hi),
        .lo_char (rchk_lo)
    );

    assign body_len = is_id_wr ? `HLI_HDR_LEN : 4'(`HLI_HDR_LEN + `HLI_DATA_LEN);

    // Reply image: [@ id] header [value] [check] * CR
    always_comb begin
        rep     = '0;
        // Longest reply, a multi-point read, needs eleven of the twelve bytes
        rep_len = 4'(ofs + body_len + `HLI_TAIL_LEN);
        if (r.mp) begin
            rep[0]  = `HLI_CHAR_AT;
            rep[1]  = rid_hi;
            rep[2]  = rid_lo;
            rep_len = 4'(rep_len + `HLI_CHK_LEN);
        end
        rep[ofs]              = hdr0;
        rep[4'(ofs + 4'h1)]   = hdr1;
        if (!is_id_wr) begin
            rep[4'(ofs + 4'h2)] = rval_hi;
            rep[4'(ofs + 4'h3)] = rval_lo;
        end
        if (r.mp) begin
            rep[4'(ofs + body_len)]         = rchk_hi;
            rep[4'(ofs + body_len + 4'h1)]  = rchk_lo;
            rep[4'(ofs + body_len + 4'h2)]  = `HLI_CHAR_STAR;
            rep[4'(ofs + body_len + 4'h3)]  = `HLI_CHAR_CR;
        end else begin
            rep[4'(ofs + body_len)]         = `HLI_CHAR_STAR;
            rep[4'(ofs + body_len + 4'h1)]  = `HLI_CHAR_CR;
        end
    end

    always_comb begin
        n       = r;
        n.nv_wr = 1'b0;
        // Mode pin: three stages, change taken once the last two agree
        n.sy    = {r.sy[1:0], multipoint_pin};
        if (r.sy[2] == r.sy[1]) begin
            n.mp = r.sy[2];
        end
        case (r.st)
            HLI_ST_LOAD: begin
                // Stored identifier picked up after reset release
                n.dev_id = nv_id;
                n.st     = HLI_ST_RX;
            end
            HLI_ST_RX: begin
                if (rx_valid) begin
                    if (rx_data == `HLI_CHAR_CR) begin
                        n.st = HLI_ST_EVAL;
                    end else if (r.cnt < `HLI_BUF_LEN) begin
                        n.rxb[r.cnt] = rx_data;
                        n.cnt        = 4'(r.cnt + 4'h1);
                    end else begin
                        // Overlong frame is kept out of the buffer and dropped at CR
                        n.ovf = 1'b1;
                    end
                end
            end
            HLI_ST_EVAL: begin
                n.cnt = 4'h0;
                n.ovf = 1'b0;
                n.rxb = '0;
                n.st  = HLI_ST_RX;
                // Rejected frames leave identifier and storage untouched
                if (accept) begin
                    if (is_id_wr) begin
                        // New value and its storage pulse leave on the same edge
                        n.dev_id = data_val;
                        n.nv_wr  = 1'b1;
                    end
                    n.txb     = rep;
                    n.tx_left = rep_len;
                    n.st      = HLI_ST_TX;
                end
            end
            HLI_ST_TX: begin
                // Half duplex: incoming bytes are ignored while replying
                if (tx_ready) begin
                    n.txb     = {8'h00, r.txb[`HLI_BUF_LEN-1:1]};
                    n.tx_left = 4'(r.tx_left - 4'h1);
                    if (r.tx_left == 4'h1) begin
                        n.st = HLI_ST_RX;
                    end
                end
            end
            default: begin
                n.st = HLI_ST_RX;
            end
        endcase
    end

    // Reset clears the identifier; LOAD then fetches the stored copy
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            r.st      <= HLI_ST_LOAD;
            r.sy      <= 3'h0;
            r.mp      <= 1'b0;
            r.dev_id  <= `HLI_ID_RST;
            r.nv_wr   <= 1'b0;
            r.cnt     <= 4'h0;
            r.ovf     <= 1'b0;
            r.rxb     <= '0;
            r.txb     <= '0;
            r.tx_left <= 4'h0;
        end else begin
            r <= n;
        end
    end

    // Decoded from state, so valid drops on the edge that takes the CR
    assign tx_valid   = (r.st == HLI_ST_TX);
    assign tx_data    = r.txb[0];
    assign nv_wr      = r.nv_wr;
    // Storage sees the identifier registered together with the write pulse
    assign nv_wr_id   = r.dev_id;
    assign dev_id     = r.dev_id;
    assign multipoint = r.mp;
endmodule : hli_top

`default_nettype wire

// [rtl/hli_defines.svh]
// Constants for the host link command interpreter
`ifndef HLI_DEFINES_SVH
`define HLI_DEFINES_SVH

`define HLI_BUF_LEN    4'hC
`define HLI_CNT_W      4
`define HLI_CHAR_CR    8'h0D
`define HLI_CHAR_STAR  8'h2A
`define HLI_CHAR_AT    8'h40
`define HLI_CHAR_I     8'h49
`define HLI_CHAR_R     8'h52
`define HLI_CHAR_W     8'h57
`define HLI_CHAR_O     8'h4F
`define HLI_MP_PFX     4'h3
`define HLI_CHK_LEN    4'h2
`define HLI_TAIL_LEN   4'h2
`define HLI_HDR_LEN    4'h2
`define HLI_DATA_LEN   4'h2
`define HLI_MAX_CH     8'h1F
`define HLI_ID_RST     8'h00

`endif

// [rtl/hli_pkg.sv]
// Types shared by the host link command interpreter
`default_nettype none
`include "hli_defines.svh"

package hli_pkg;

    typedef enum logic [1:0] {
        HLI_ST_LOAD,
        HLI_ST_RX,
        HLI_ST_EVAL,
        HLI_ST_TX
    } hli_state_e;

    typedef logic [7:0] hli_byte_t;

    typedef struct packed {
        hli_state_e                      st;
        logic [2:0]                      sy;
        logic                            mp;
        hli_byte_t                       dev_id;
        logic                            nv_wr;
        logic [`HLI_CNT_W-1:0]           cnt;
        logic                            ovf;
        logic [`HLI_BUF_LEN-1:0][7:0]    rxb;
        logic [`HLI_BUF_LEN-1:0][7:0]    txb;
        logic [`HLI_CNT_W-1:0]           tx_left;
    } hli_state_s;

endpackage : hli_pkg

`default_nettype wire

// [rtl/hli_hex_dec.sv]
// Two ASCII hex characters to one byte
`default_nettype none

module hli_hex_dec (
    input  wire logic [7:0] hi_char,
    input  wire logic [7:0] lo_char,
    output logic      [7:0] value,
    output logic            ok
);
    import hli_pkg::*;

    function automatic logic [4:0] hli_nib(input logic [7:0] c);
        logic [4:0] res;
        res = 5'h00;
        if (c >= 8'h30 && c <= 8'h39) begin
            res = {1'b1, c[3:0]};
        end else if ((c >= 8'h41 && c <= 8'h46) || (c >= 8'h61 && c <= 8'h66)) begin
            res = {1'b1, 4'(c[3:0] + 4'h9)};
        end
        return res;
    endfunction : hli_nib

    logic [4:0] hi_n;
    logic [4:0] lo_n;

    assign hi_n  = hli_nib(hi_char);
    assign lo_n  = hli_nib(lo_char);
    assign value = {hi_n[3:0], lo_n[3:0]};
    assign ok    = hi_n[4] & lo_n[4];
endmodule : hli_hex_dec

`default_nettype wire

// [rtl/hli_hex_enc.sv]
// One byte to two upper-case ASCII hex characters
`default_nettype none

module hli_hex_enc (
    input  wire logic [7:0] value,
    output logic      [7:0] hi_char,
    output logic      [7:0] lo_char
);
    import hli_pkg::*;

    function automatic logic [7:0] hli_chr(input logic [3:0] n);
        return (n < 4'hA) ? {4'h3, n} : 8'(8'h37 + {4'h0, n});
    endfunction : hli_chr

    assign hi_char = hli_chr(value[7:4]);
    assign lo_char = hli_chr(value[3:0]);
endmodule : hli_hex_enc

`default_nettype wire

// [dv/hli_top_monitor.sv]
// Port-level checker for the host link interpreter
`default_nettype none

module hli_top_monitor (
    input wire logic       clk,
    input wire logic       nrst,
    input wire logic       multipoint_pin,
    input wire logic [7:0] rx_data,
    input wire logic       rx_valid,
    input wire logic [7:0] tx_data,
    input wire logic       tx_valid,
    input wire logic       tx_ready,
    input wire logic       nv_wr,
    input wire logic [7:0] nv_wr_id,
    input wire logic [7:0] dev_id,
    input wire logic       multipoint
);
    timeunit 1ns;
    timeprecision 1ns;
    logic cr_in;
    assign cr_in = rx_valid && (rx_data == 8'h0D);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    reply_lat_a: assert property ($rose(tx_valid) |-> $past(cr_in, 2))
        else $error("reply not two cycles after frame end");
    char_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
        else $error("reply char not held");
    end_cr_a: assert property (tx_valid && tx_ready && tx_data == 8'h0D |=> !tx_valid)
        else $error("reply runs past CR");
    fall_cr_a: assert property ($fell(tx_valid) |-> $past(tx_data) == 8'h0D && $past(tx_ready))
        else $error("reply ends without CR");
    p2p_head_a: assert property ($rose(tx_valid) && !multipoint |-> tx_data inside {8'h49, 8'h52})
        else $error("p2p reply has a prefix");
    mp_head_a: assert property ($rose(tx_valid) && multipoint |-> tx_data == 8'h40)
        else $error("mp reply lacks prefix");
    wr_pulse_a: assert property (nv_wr |-> $rose(tx_valid) ##1 !nv_wr)
        else $error("store pulse misplaced");
    wr_val_a: assert property (nv_wr |-> nv_wr_id == dev_id)
        else $error("stored id differs");
    id_keep_a: assert property ($changed(dev_id) && nrst && $past(nrst, 2) |-> nv_wr)
        else $error("id changed without a write");
    mode_sync_a: assert property ($changed(multipoint) |-> multipoint == multipoint_pin)
        else $error("mode differs from strap");

    cover property (nv_wr);
    cover property ($rose(tx_valid) && multipoint);
    cover property (tx_valid && !tx_ready);
endmodule : hli_top_monitor

bind hli_top hli_top_monitor u_hli_top_monitor (.clk, .nrst, .multipoint_pin, .rx_data, .rx_valid,
    .tx_data, .tx_valid, .tx_ready, .nv_wr, .nv_wr_id, .dev_id, .multipoint);

`default_nettype wire

// [dv/hli_host.sv]
// Host-side model: sends queued frames, drains replies with stalls
`default_nettype none

module hli_host (
    input  wire logic       clk,
    output var  logic [7:0] rx_data,
    output var  logic       rx_valid,
    input  wire logic [7:0] tx_data,
    input  wire logic       tx_valid,
    output var  logic       tx_ready
);
    timeunit 1ns;
    timeprecision 1ns;
    byte        q_out[$];
    logic [7:0] got[$];

    initial begin
        rx_data = 8'h00;
        rx_valid = 1'b0;
        tx_ready = 1'b0;
    end

    always @(posedge clk) begin
        tx_ready <= ($urandom_range(3) != 0);
        if (tx_valid && tx_ready) got.push_back(tx_data);
        // Bench queues a frame only once the reply is over
        if (q_out.size() != 0 && $urandom_range(1) == 1) begin
            rx_data <= q_out.pop_front();
            rx_valid <= 1'b1;
        end else begin
            // Idle line must not look like the last char
            rx_data <= ~rx_data;
            rx_valid <= 1'b0;
        end
    end
endmodule : hli_host

`default_nettype wire

// [dv/host_link_id_and_io_read_test.sv]
// Self-checking bench for the host link interpreter
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin err_total++; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, a, b); end end

module host_link_id_and_io_read_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic         clk, nrst, multipoint_pin, rx_valid, tx_valid, tx_ready;
    logic         nv_wr, multipoint;
    logic [7:0]   rx_data, tx_data, nv_id, nv_wr_id, dev_id;
    logic [255:0] in_img, out_img;
    int           err_total = 0;
    int           cmp_count = 0;
    int           cyc = 0;
    int           chs[4];
    byte          id;

    hli_top u_hli_top (.clk, .nrst, .multipoint_pin, .rx_data, .rx_valid, .tx_data, .tx_valid,
        .tx_ready, .in_image(in_img), .out_image(out_img), .nv_id, .nv_wr, .nv_wr_id, .dev_id,
        .multipoint);
    hli_host u_hli_host (.clk, .rx_data, .rx_valid, .tx_data, .tx_valid, .tx_ready);

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (nv_wr) nv_id <= nv_wr_id; // Storage survives reset
        if (cyc == 20000) begin
            err_total++;
            final_report();
        end
    end

    function automatic string hx(byte v);
        string d = "0123456789ABCDEF";
        string s = "00";
        s[0] = d[v[7:4]];
        s[1] = d[v[3:0]];
        return s;
    endfunction : hx

    function automatic string mkf(bit mp, byte d, string b, bit bad);
        string s;
        byte   c;
        s = mp ? {"@", hx(d), b} : b;
        c = 0;
        foreach (s[i]) c ^= s[i];
        return mp ? {s, hx(c ^ byte'(bad)), "*"} : {s, "*"};
    endfunction : mkf

    // Empty rb means the frame must be ignored
    task automatic run(bit mp, byte fid, string b, bit bad, string rb);
        string f, e;
        f = {mkf(mp, fid, b, bad), "\015"};
        e = (rb == "") ? "" : {mkf(mp, id, rb, 1'b0), "\015"};
        u_hli_host.got.delete();
        foreach (f[i]) u_hli_host.q_out.push_back(f[i]);
        repeat (400) begin
            @(negedge clk);
            if (u_hli_host.q_out.size() == 0 && u_hli_host.got.size() == e.len() && tx_valid === 1'b0) break;
        end
        repeat (20) @(negedge clk);
        `CHK(u_hli_host.got.size(), e.len())
        foreach (e[i]) if (i < u_hli_host.got.size()) `CHK(u_hli_host.got[i], e[i])
        $display("test %s mp=%0d done", b, mp);
    endtask : run

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : final_report

    initial begin
        nrst = 1'b0;
        multipoint_pin = 1'b0;
        void'($urandom(29128));
        for (int i = 0; i < 8; i++) begin
            in_img[i*32 +: 32] = $urandom();
            out_img[i*32 +: 32] = $urandom();
        end
        nv_id = 8'($urandom());
        id = nv_id;
        chs = '{0, 31, $urandom_range(30, 1), $urandom_range(30, 1)};
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        repeat (4) @(negedge clk);
        `CHK(dev_id, id)
        run(0, 0, "IR", 0, {"IR", hx(id)});
        foreach (chs[k]) begin
            run(0, 0, {"RI", hx(chs[k])}, 0, {"RI", hx(in_img[chs[k]*8 +: 8])});
            run(0, 0, {"RO", hx(chs[k])}, 0, {"RO", hx(out_img[chs[k]*8 +: 8])});
        end
        run(0, 0, "RI20", 0, "");
        id = 8'($urandom());
        run(0, 0, {"IW", hx(id)}, 0, "IW");
        `CHK(dev_id, id)
        @(posedge clk);
        multipoint_pin <= 1'b1;
        repeat (8) @(negedge clk);
        `CHK(multipoint, 1'b1)
        run(1, id, "IR", 0, {"IR", hx(id)});
        run(1, id, {"RO", hx(chs[2])}, 0, {"RO", hx(out_img[chs[2]*8 +: 8])});
        run(1, byte'(id + 1), "IR", 0, "");
        run(1, id, {"IW", hx(~id)}, 1, "");
        `CHK(dev_id, id)
        // Reply to a write is still framed with the identifier it was sent to
        run(1, id, {"IW", hx(~id)}, 0, "IW");
        id = ~id;
        `CHK(nv_wr_id, id)
        @(posedge clk);
        multipoint_pin <= 1'b0;
        repeat (8) @(negedge clk);
        run(0, 0, "IR", 0, {"IR", hx(id)});
        @(posedge clk);
        nrst <= 1'b0;
        @(posedge clk);
        nrst <= 1'b1;
        repeat (4) @(negedge clk);
        `CHK(dev_id, id)
        final_report();
    end
endmodule : host_link_id_and_io_read_test

`default_nettype wire
